// File: design/ptw_pkg.sv
package ptw_pkg;
	// register byte offsets
	localparam logic [4:0] PTW_CFG_OFS = 5'h00;
	localparam logic [4:0] PTW_PRESC_OFS = 5'h04;
	localparam logic [4:0] PTW_PRESET_OFS = 5'h08;
	localparam logic [4:0] PTW_CSR_OFS = 5'h0C;
	localparam logic [4:0] PTW_WATCHDOG_COUNT_REG_OFS = 5'h10;
	localparam logic [4:0] PTW_MATCH_OFS = 5'h14;
	// config bit positions
	localparam int PTW_LK_CFG = 0;
	localparam int PTW_LK_PRESC = 1;
	localparam int PTW_LK_TMR = 2;
	localparam int PTW_LK_WATCHDOG_COUNT_REG = 3;
	localparam int PTW_WD_CLK_SEL = 4;
	localparam int PTW_MATCH_EN = 5;
	localparam int PTW_CFG_W = 6;
	// status/control bit positions
	localparam int PTW_CSR_RESTART = 0;
	localparam int PTW_CSR_TC = 1;
	localparam int PTW_CSR_INTE = 2;
	// reset values and keys
	localparam logic [15:0] PTW_PRESET_RST = 16'hFFFF;
	localparam logic [7:0] PTW_WATCHDOG_COUNT_REG_RST = 8'h0F;
	localparam logic [7:0] PTW_MATCH_KEY = 8'h5C;
	localparam logic [2:0] PTW_DIV_MAX = 3'h5;
	localparam int PTW_PRESC_W = 5;
	// power modes
	typedef enum logic [1:0] {
		PTW_ACTIVE,
		PTW_SAVE,
		PTW_IDLE,
		PTW_HALT
	} ptw_mode_t;
endpackage

// File: design/ptw_top.sv
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
module ptw_top #(
	parameter int TMR_W = 16,
	parameter int WD_W = 8
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// slow clock enable and power mode
	input wire logic slow_clock_en_i,
	input wire ptw_pkg::ptw_mode_t power_mode_i,
	// avalon-mm slave
	input wire logic [4:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// timer and watchdog outputs
	output logic timer_tick_o,
	output logic real_time_irq_o,
	output logic watchdog_running_o,
	output logic watchdog_error_o
);
	import ptw_pkg::*;

	if (TMR_W != 16 || WD_W != 8) begin : g_width_check
		$error("ptw_top: only 16-bit timer and 8-bit watchdog supported");
	end

	logic rst_meta_reg;
	logic rst_n;
	logic [PTW_CFG_W-1:0] cfg_reg;
	logic [2:0] div_reg;
	logic [TMR_W-1:0] preset_reg;
	logic [TMR_W-1:0] tcnt_reg;
	logic restart_reg;
	logic tc_reg;
	logic inte_reg;
	logic [WD_W-1:0] watchdog_count_reg_reg;
	logic [WD_W-1:0] wd_reg;
	logic wd_run_reg;
	logic serviced_reg;
	logic [PTW_PRESC_W-1:0] presc_reg;
	logic halt;
	logic slow_en;
	logic [2:0] div_eff;
	logic [5:0] mask_full;
	logic [PTW_PRESC_W-1:0] mask;
	logic pre_en;
	logic tick_en;
	logic wd_en;
	logic req;
	logic wr_acc;
	logic rd_acc;
	logic reach;
	logic [7:0] wbyte;
	logic wr_cfg;
	logic wr_presc;
	logic wr_preset;
	logic wr_csr;
	logic wr_watchdog_count_reg;
	logic wr_match;
	logic service;
	logic bad_match;
	logic late;
	logic [31:0] rd_next;

	// reset release through two flops
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	assign halt = (power_mode_i == PTW_HALT);
	assign slow_en = slow_clock_en_i && !halt;

	// bus access decode
	assign req = read_i || write_i;
	assign wr_acc = write_i && !waitrequest_o;
	assign rd_acc = read_i && !waitrequest_o;
	assign wbyte = writedata_i[7:0];

	function automatic logic reach_f(input logic [4:0] a, input ptw_mode_t m);
		logic r;
		r = 1'b0;
		case (m)
			PTW_ACTIVE: r = 1'b1;
			PTW_SAVE, PTW_IDLE: r = (a == PTW_MATCH_OFS);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	assign reach = reach_f(address_i, power_mode_i);

	assign wr_cfg = wr_acc && reach && address_i == PTW_CFG_OFS
		&& !cfg_reg[PTW_LK_CFG];
	assign wr_presc = wr_acc && reach && address_i == PTW_PRESC_OFS
		&& !cfg_reg[PTW_LK_PRESC];
	assign wr_preset = wr_acc && reach && address_i == PTW_PRESET_OFS
		&& !cfg_reg[PTW_LK_TMR];
	assign wr_csr = wr_acc && reach && address_i == PTW_CSR_OFS
		&& !cfg_reg[PTW_LK_TMR];
	assign wr_watchdog_count_reg = wr_acc && reach && address_i == PTW_WATCHDOG_COUNT_REG_OFS
		&& !cfg_reg[PTW_LK_WATCHDOG_COUNT_REG];
	assign wr_match = wr_acc && reach && address_i == PTW_MATCH_OFS;

	// one wait cycle, then a single ready cycle
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest_o <= 1'b1;
		end else begin
			waitrequest_o <= !(req && waitrequest_o);
		end
	end

	// locked or write-only reads return zero
	always_comb begin
		rd_next = 32'h0000_0000;
		if (reach) begin
			case (address_i)
				PTW_CFG_OFS: begin
					if (!cfg_reg[PTW_LK_CFG]) rd_next[PTW_CFG_W-1:0] = cfg_reg;
				end
				PTW_PRESC_OFS: begin
					if (!cfg_reg[PTW_LK_PRESC]) rd_next[2:0] = div_reg;
				end
				PTW_PRESET_OFS: begin
					if (!cfg_reg[PTW_LK_TMR]) rd_next[TMR_W-1:0] = preset_reg;
				end
				PTW_CSR_OFS: begin
					if (!cfg_reg[PTW_LK_TMR]) begin
						rd_next[PTW_CSR_RESTART] = restart_reg;
						rd_next[PTW_CSR_TC] = tc_reg;
						rd_next[PTW_CSR_INTE] = inte_reg;
					end
				end
				default: rd_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			readdata_o <= 32'h0000_0000;
		end else if (req && waitrequest_o) begin
			readdata_o <= rd_next;
		end
	end

	// lock and config bits only ever set
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= '0;
		end else if (wr_cfg) begin
			cfg_reg <= cfg_reg | wbyte[PTW_CFG_W-1:0];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 3'h0;
			preset_reg <= PTW_PRESET_RST;
			inte_reg <= 1'b0;
		end else begin
			if (wr_presc) div_reg <= wbyte[2:0];
			if (wr_preset) preset_reg <= writedata_i[TMR_W-1:0];
			if (wr_csr) inte_reg <= wbyte[PTW_CSR_INTE];
		end
	end

	// prescaler enable every 2^div slow edges, div capped at 5
	assign div_eff = (div_reg > PTW_DIV_MAX) ? PTW_DIV_MAX : div_reg;
	assign mask_full = (6'h01 << div_eff) - 6'h01;
	assign mask = mask_full[PTW_PRESC_W-1:0];
	assign pre_en = slow_en && ((presc_reg & mask) == mask);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			presc_reg <= '0;
		end else if (slow_en) begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	// zero reached on this prescaled edge
	assign tick_en = pre_en && !restart_reg && tcnt_reg == 1;

	// down count, reload at zero, restart reload
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tcnt_reg <= PTW_PRESET_RST;
		end else if (pre_en) begin
			if (restart_reg || tcnt_reg == 0) begin
				tcnt_reg <= preset_reg;
			end else begin
				tcnt_reg <= tcnt_reg - 1'b1;
			end
		end
	end

	// restart set by software, cleared at reload
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			restart_reg <= 1'b0;
		end else if (wr_csr && wbyte[PTW_CSR_RESTART]) begin
			restart_reg <= 1'b1;
		end else if (pre_en) begin
			restart_reg <= 1'b0;
		end
	end

	// tick level for one prescaled cycle
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			timer_tick_o <= 1'b0;
		end else if (pre_en) begin
			timer_tick_o <= tick_en;
		end
	end

	// terminal count set, cleared by read, set wins
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tc_reg <= 1'b0;
		end else if (tick_en) begin
			tc_reg <= 1'b1;
		end else if (rd_acc && reach && address_i == PTW_CSR_OFS
			&& !cfg_reg[PTW_LK_TMR]) begin
			tc_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			real_time_irq_o <= 1'b0;
		end else begin
			real_time_irq_o <= tick_en && inte_reg;
		end
	end

	assign wd_en = cfg_reg[PTW_WD_CLK_SEL] ? pre_en : tick_en;

	assign service = (wr_watchdog_count_reg && !cfg_reg[PTW_MATCH_EN])
		|| (wr_match && cfg_reg[PTW_MATCH_EN] && wbyte == PTW_MATCH_KEY);
	assign bad_match = wr_match && cfg_reg[PTW_MATCH_EN]
		&& wbyte != PTW_MATCH_KEY;
	// counter at zero on its clock
	assign late = wd_run_reg && wd_en && wd_reg == 0;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_count_reg_reg <= PTW_WATCHDOG_COUNT_REG_RST;
		end else if (wr_watchdog_count_reg) begin
			watchdog_count_reg_reg <= wbyte[WD_W-1:0];
		end
	end

	// off after reset, start and never stop
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			wd_run_reg <= 1'b0;
		end else if (wr_watchdog_count_reg || wr_match) begin
			wd_run_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			wd_reg <= PTW_WATCHDOG_COUNT_REG_RST;
		end else if (wr_watchdog_count_reg && !wd_run_reg) begin
			wd_reg <= wbyte[WD_W-1:0];
		end else if (service) begin
			wd_reg <= wr_watchdog_count_reg ? wbyte[WD_W-1:0] : watchdog_count_reg_reg;
		end else if (wd_run_reg && wd_en && wd_reg != 0) begin
			wd_reg <= wd_reg - 1'b1;
		end
	end

	// one service per watchdog clock cycle
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			serviced_reg <= 1'b0;
		end else if (service) begin
			serviced_reg <= 1'b1;
		end else if (wd_en) begin
			serviced_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_error_o <= 1'b0;
		end else if (late || bad_match || (service && serviced_reg)) begin
			watchdog_error_o <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_running_o <= 1'b0;
		end else begin
			watchdog_running_o <= wd_run_reg;
		end
	end

	// checks
	presc_gate_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		pre_en |-> slow_clock_en_i && !halt)
		else $error("prescaled enable without slow edge");
	timer_dec_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		pre_en && !restart_reg && tcnt_reg != 0 |=>
		tcnt_reg == $past(tcnt_reg) - 1'b1)
		else $error("timer did not decrement");
	timer_reload_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		pre_en && tcnt_reg == 0 |=> tcnt_reg == $past(preset_reg))
		else $error("timer did not reload at zero");
	tick_pulse_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		tick_en |=> timer_tick_o && tcnt_reg == 0)
		else $error("tick missing at zero");
	tc_irq_set_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		tick_en |=> tc_reg && (real_time_irq_o == $past(inte_reg)))
		else $error("flag or interrupt missing on tick");
	restart_done_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		pre_en && restart_reg && !wr_csr |=>
		!restart_reg && tcnt_reg == $past(preset_reg))
		else $error("restart not completed");
	// a first match write also starts the watchdog
	wd_idle_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		!wd_run_reg && !wr_watchdog_count_reg && !wr_match |=> $stable(wd_reg) && !watchdog_error_o)
		else $error("watchdog active before start");
	wd_late_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		late |=> watchdog_error_o)
		else $error("late service not flagged");
	wd_key_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		bad_match |=> watchdog_error_o)
		else $error("wrong key not flagged");
	lock_hold_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		1'b1 |=> (cfg_reg & $past(cfg_reg)) == $past(cfg_reg))
		else $error("config bit cleared by software");
	halt_freeze_a: assert property (
		@(posedge clock_i) disable iff (!rst_n)
		halt |=> $stable(tcnt_reg) && $stable(presc_reg))
		else $error("counting during halt");
endmodule

// File: sim/ptw_top_tb.sv
`timescale 1ns/10ps
module ptw_top_tb;
	import ptw_pkg::*;
	logic clock_i;
	logic rst_b_i;
	logic slow_clock_en_i = 1'b0;
	ptw_mode_t power_mode_i;
	logic [4:0] address_i;
	logic read_i;
	logic write_i;
	logic [31:0] writedata_i;
	logic [31:0] readdata_o;
	logic waitrequest_o;
	logic timer_tick_o;
	logic real_time_irq_o;
	logic watchdog_running_o;
	logic watchdog_error_o;
	int miscompares = 0;
	int n_tests = 0;
	int seed = 32'h4e3e357c;
	logic [1:0] sc = 2'h0;
	int slow_n = 0;
	int tick_cnt = 0;
	int irq_cnt = 0;
	int last_at = 0;
	int gap = 0;
	int k;
	int p;
	int d;
	logic tick_q = 1'b0;
	logic [31:0] q;
	logic [31:0] v;
	logic [4:0] ofs [7] = '{PTW_CFG_OFS, PTW_PRESC_OFS, PTW_PRESET_OFS, PTW_CSR_OFS,
		PTW_WATCHDOG_COUNT_REG_OFS, PTW_MATCH_OFS, 5'h18};
	logic [31:0] rv [7] = '{32'h0, 32'h0, {16'h0, PTW_PRESET_RST}, 32'h0, 32'h0, 32'h0, 32'h0};

	ptw_top DUT (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.slow_clock_en_i(slow_clock_en_i),
		.power_mode_i(power_mode_i),
		.address_i(address_i),
		.read_i(read_i),
		.write_i(write_i),
		.writedata_i(writedata_i),
		.readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o),
		.timer_tick_o(timer_tick_o),
		.real_time_irq_o(real_time_irq_o),
		.watchdog_running_o(watchdog_running_o),
		.watchdog_error_o(watchdog_error_o)
	);

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// slow edge every fourth cycle; tick spacing counted in slow edges
	always @(posedge clock_i) begin
		sc <= sc + 2'h1;
		slow_clock_en_i <= (sc == 2'h3);
		if (slow_clock_en_i === 1'b1) slow_n <= slow_n + 1;
		tick_q <= timer_tick_o;
		if (timer_tick_o === 1'b1 && tick_q !== 1'b1) begin
			tick_cnt <= tick_cnt + 1;
			gap <= slow_n - last_at;
			last_at <= slow_n;
		end
		if (real_time_irq_o === 1'b1) irq_cnt <= irq_cnt + 1;
	end

	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		address_i <= a;
		writedata_i <= dat;
		read_i <= ~wr;
		write_i <= wr;
		@(posedge clock_i);
		while (waitrequest_o !== 1'b0 && n < 20) begin
			@(posedge clock_i);
			n++;
		end
		if (n >= 20) check(1'b0, 1'b1, "bus hang");
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic do_reset;
		rst_b_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clock_i);
	endtask

	task automatic wait_ticks(input int n);
		int t;
		int g;
		t = tick_cnt + n;
		g = 0;
		while (tick_cnt < t && g < 20000) begin
			@(posedge clock_i);
			g++;
		end
		if (g >= 20000) check(1'b0, 1'b1, "no tick");
	endtask

	function automatic logic [31:0] period(input int pr, input int dv);
		return (pr + 1) << dv;
	endfunction

	task automatic timer_case(input int pr, input int dv, input logic ie);
		int t0;
		int i0;
		bus(1'b1, PTW_PRESC_OFS, dv);
		bus(1'b1, PTW_PRESET_OFS, pr);
		bus(1'b1, PTW_CSR_OFS, {29'h0, ie, 2'h1});
		// a tick under the old enable is counted before the snapshot
		@(posedge clock_i);
		t0 = tick_cnt;
		i0 = irq_cnt;
		wait_ticks(3);
		check(gap, period(pr, dv), "tick period");
		check(irq_cnt - i0, ie ? tick_cnt - t0 : 0, "irq count");
		// both reads land before the next tick, even at the shortest period
		bus(1'b0, PTW_CSR_OFS, 32'h0);
		check(q[2:0], {ie, 2'b10}, "csr after tick");
		bus(1'b0, PTW_CSR_OFS, 32'h0);
		check(q[1], 1'b0, "tc cleared");
		$display("test done: timer preset %0d div %0d", pr, dv);
	endtask

	initial begin
		rst_b_i = 1'b0;
		power_mode_i = PTW_ACTIVE;
		address_i = 5'h00;
		read_i = 1'b0;
		write_i = 1'b0;
		writedata_i = 32'h0;
		do_reset;
		check({watchdog_running_o, watchdog_error_o}, 2'b00, "watchdog idle");
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, ofs[i], 32'h0);
			check(q, rv[i], "reset value");
		end
		$display("test done: reset values");
		timer_case(1, 0, 1'b1);
		for (int i = 0; i < 4; i++) begin
			p = 1 + $unsigned($random(seed)) % 6;
			d = i == 0 ? 5 : $unsigned($random(seed)) % 6;
			v = $random(seed);
			timer_case(p, d, v[0]);
		end
		bus(1'b1, PTW_PRESET_OFS, 32'h4);
		wait_ticks(3);
		check(gap, period(4, d), "new preset");
		// halt freezes, save keeps counting
		timer_case(1, 0, 1'b0);
		power_mode_i <= PTW_HALT;
		repeat (3) @(posedge clock_i);
		k = tick_cnt;
		repeat (100) @(posedge clock_i);
		check(tick_cnt, k, "halt frozen");
		bus(1'b0, PTW_PRESET_OFS, 32'h0);
		check(q, 32'h0, "halt read");
		// restart seen done and far more than 5 slow cycles ago
		power_mode_i <= PTW_SAVE;
		repeat (40) @(posedge clock_i);
		check(tick_cnt > k, 1'b1, "save counts");
		bus(1'b0, PTW_PRESET_OFS, 32'h0);
		check(q, 32'h0, "save read");
		power_mode_i <= PTW_ACTIVE;
		bus(1'b0, PTW_PRESET_OFS, 32'h0);
		check(q, 32'h1, "active read");
		$display("test done: power modes");
		bus(1'b1, PTW_CFG_OFS, 32'h2);
		bus(1'b1, PTW_PRESC_OFS, 32'h3);
		bus(1'b0, PTW_PRESC_OFS, 32'h0);
		check(q, 32'h0, "locked read");
		wait_ticks(3);
		check(gap, period(1, 0), "locked prescale");
		bus(1'b1, PTW_CFG_OFS, 32'h0);
		bus(1'b0, PTW_CFG_OFS, 32'h0);
		check(q, 32'h2, "lock sticks");
		bus(1'b1, PTW_CFG_OFS, 32'h1);
		bus(1'b0, PTW_CFG_OFS, 32'h0);
		check(q, 32'h0, "cfg locked");
		$display("test done: locking");
		do_reset;
		bus(1'b1, PTW_CFG_OFS, 32'h10);
		bus(1'b1, PTW_MATCH_OFS, 32'h12);
		// running flag trails the start by one cycle
		@(posedge clock_i);
		check({watchdog_running_o, watchdog_error_o}, 2'b10, "match start");
		repeat (10) begin
			bus(1'b1, PTW_WATCHDOG_COUNT_REG_OFS, 32'h5);
			repeat (5) @(posedge clock_i);
		end
		check(watchdog_error_o, 1'b0, "count service");
		repeat (40) @(posedge clock_i);
		check({watchdog_running_o, watchdog_error_o}, 2'b11, "late");
		$display("test done: count service");
		do_reset;
		bus(1'b1, PTW_CFG_OFS, 32'h30);
		bus(1'b1, PTW_WATCHDOG_COUNT_REG_OFS, 32'h6);
		repeat (10) begin
			bus(1'b1, PTW_MATCH_OFS, {24'h0, PTW_MATCH_KEY});
			repeat (5) @(posedge clock_i);
		end
		check({watchdog_running_o, watchdog_error_o}, 2'b10, "match service");
		v = $random(seed);
		if (v[7:0] == PTW_MATCH_KEY) v[7:0] = 8'h5D;
		bus(1'b1, PTW_MATCH_OFS, {24'h0, v[7:0]});
		repeat (3) @(posedge clock_i);
		check(watchdog_error_o, 1'b1, "wrong key");
		$display("test done: match service");
		do_reset;
		bus(1'b1, PTW_CFG_OFS, 32'h20);
		bus(1'b1, PTW_WATCHDOG_COUNT_REG_OFS, 32'h1);
		repeat (160) @(posedge clock_i);
		check(watchdog_error_o, 1'b0, "tick clocked");
		bus(1'b1, PTW_MATCH_OFS, {24'h0, PTW_MATCH_KEY});
		bus(1'b1, PTW_MATCH_OFS, {24'h0, PTW_MATCH_KEY});
		repeat (3) @(posedge clock_i);
		check(watchdog_error_o, 1'b1, "too often");
		$display("test done: double service");
		end_of_test;
	end

	initial begin
		#800000;
		miscompares++;
		$display("MISMATCH at %0t: timeout", $time);
		end_of_test;
	end
endmodule
